//--- inc/aat_pkg.sv
// Shared constants, ranges and state encodings for the arc alarm trip sequencer.
package aat_pkg;

  // Clock and the tenth-of-a-second time base.
  localparam int CLK_PERIOD_NS = 8;
  localparam int TENTH_NS = 100000000;
  localparam int TENTH_CYCLES = TENTH_NS / CLK_PERIOD_NS;
  localparam int PRESC_W = 24;
  localparam int TW = 12;

  // Times in their own units, then converted to tenth-second ticks.
  localparam int RECLOSE_MIN = 3;
  localparam int KEY_IDLE_S = 10;
  localparam int DIM_S = 5;
  localparam int CLEAR_HOLD_MS = 1500;
  localparam logic [TW-1:0] RECLOSE_TENTHS = TW'(RECLOSE_MIN * 600);
  localparam logic [TW-1:0] KEY_IDLE_TENTHS = TW'(KEY_IDLE_S * 10);
  localparam logic [TW-1:0] DIM_TENTHS = TW'((KEY_IDLE_S + DIM_S) * 10);
  localparam logic [TW-1:0] CLEAR_HOLD_TENTHS = TW'(CLEAR_HOLD_MS / 100);
  localparam logic [TW-1:0] TENTHS_PER_S = 12'h00a;

  // Alarm counting.
  localparam logic [2:0] ALARM_MAX = 3'h5;
  localparam logic [2:0] ALARM_ZERO = 3'h0;

  // Host word addresses and values.
  localparam logic [15:0] HOST_CLEAR_ADDR = 16'h0079;
  localparam logic [15:0] HOST_CLEAR_VALUE = 16'h0001;
  localparam logic [15:0] HOST_BAR_ADDR = 16'h0b16;
  localparam logic [15:0] BAR_RANGE_DEF = 16'h000a;

  // Setting items, addressed by cursor index.
  localparam int ITEMS = 7;
  localparam logic [2:0] IT_ADDR = 3'h0;
  localparam logic [2:0] IT_PAR = 3'h1;
  localparam logic [2:0] IT_BAUD = 3'h2;
  localparam logic [2:0] IT_MODE = 3'h3;
  localparam logic [2:0] IT_THR = 3'h4;
  localparam logic [2:0] IT_IAT = 3'h5;
  localparam logic [2:0] IT_CAT = 3'h6;
  localparam logic [2:0] IT_FIRST = 3'h0;
  localparam logic [2:0] IT_LAST = 3'h6;

  // Parity codes: none, odd, even. Baud codes: 2400, 4800, 9600, 19200, 38400.
  localparam logic [7:0] PAR_NONE = 8'h00;
  localparam logic [7:0] PAR_EVEN = 8'h02;
  localparam logic [7:0] BAUD_2400 = 8'h00;
  localparam logic [7:0] BAUD_9600 = 8'h02;
  localparam logic [7:0] BAUD_38400 = 8'h04;
  localparam logic [7:0] MODE_CONT = 8'h00;
  localparam logic [7:0] MODE_SINGLE = 8'h01;

  localparam logic [7:0] ITEM_MIN [ITEMS] = '{8'h01, PAR_NONE, BAUD_2400, MODE_CONT,
                                             8'h00, 8'h01, 8'h05};
  localparam logic [7:0] ITEM_MAX [ITEMS] = '{8'hf7, PAR_EVEN, BAUD_38400, MODE_SINGLE,
                                             8'hff, 8'h05, 8'h3c};
  localparam logic [7:0] ITEM_DEF [ITEMS] = '{8'hf7, PAR_NONE, BAUD_9600, MODE_CONT,
                                             8'h80, 8'h01, 8'h05};

  // Key bit positions.
  localparam int K_BACK = 0;
  localparam int K_MINUS = 1;
  localparam int K_PLUS = 2;
  localparam int K_SET = 3;

  typedef enum logic [7:0] {
    SCR_DEFAULT = 8'h01,
    SCR_BROWSE = 8'h02,
    SCR_EDIT = 8'h04,
    SCR_VERSION = 8'h08,
    SCR_CALIB = 8'h10,
    SCR_SELFCHECK = 8'h20,
    SCR_CLEARED = 8'h40,
    SCR_ALARM = 8'h80
  } aat_screen_t;

  typedef enum logic [2:0] {
    TRIP_NORMAL = 3'h1,
    TRIP_OPEN = 3'h2,
    TRIP_LOCKOUT = 3'h4
  } aat_trip_t;

  typedef enum logic [3:0] {
    CLS_IDLE = 4'h1,
    CLS_ARC = 4'h2,
    CLS_GAP = 4'h4,
    CLS_HOLD = 4'h8
  } aat_cls_t;

endpackage

//--- inc/aat_cls_if.sv
// Link between the sequencer and its arc event classifier.
`timescale 1ns/100ps
interface aat_cls_if;
  logic tick;
  logic arc_on;
  logic [aat_pkg::TW-1:0] iat_lim;
  logic [aat_pkg::TW-1:0] cat_lim;
  logic onset;
  logic inst_evt;
  logic cont_evt;
  modport seq (output tick, output arc_on, output iat_lim, output cat_lim,
               input onset, input inst_evt, input cont_evt);
  modport cls (input tick, input arc_on, input iat_lim, input cat_lim,
               output onset, output inst_evt, output cont_evt);
endinterface

//--- rtl/aat_arc_classifier.sv
// Arc event classifier: instantaneous or continuous by duration and repeat window.
`timescale 1ns/100ps
module aat_arc_classifier (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Sequencer side
  aat_cls_if.cls c
);

  aat_pkg::aat_cls_t state_reg;
  aat_pkg::aat_cls_t state_next;
  logic [aat_pkg::TW-1:0] cnt_reg;
  logic [aat_pkg::TW-1:0] cnt_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    c.onset = 1'b0;
    c.inst_evt = 1'b0;
    c.cont_evt = 1'b0;
    case (state_reg)
      aat_pkg::CLS_IDLE: begin
        if (c.arc_on) begin
          c.onset = 1'b1;
          cnt_next = '0;
          state_next = aat_pkg::CLS_ARC;
        end
      end
      aat_pkg::CLS_ARC: begin
        if (!c.arc_on) begin
          cnt_next = '0;
          state_next = aat_pkg::CLS_GAP;
        end else if (c.tick) begin
          cnt_next = cnt_reg + 1'b1;
          if (cnt_reg >= c.iat_lim) begin
            c.cont_evt = 1'b1;
            state_next = aat_pkg::CLS_HOLD;
          end
        end
      end
      aat_pkg::CLS_GAP: begin
        if (c.arc_on) begin
          c.cont_evt = 1'b1;
          state_next = aat_pkg::CLS_HOLD;
        end else if (c.tick) begin
          cnt_next = cnt_reg + 1'b1;
          if (cnt_next >= c.cat_lim) begin
            c.inst_evt = 1'b1;
            state_next = aat_pkg::CLS_IDLE;
          end
        end
      end
      aat_pkg::CLS_HOLD: begin
        if (!c.arc_on) begin
          state_next = aat_pkg::CLS_IDLE;
        end
      end
      default: begin
        state_next = aat_pkg::CLS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= aat_pkg::CLS_IDLE;
      cnt_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

endmodule

//--- rtl/aat_sequencer.sv
// Arc alarm trip sequencer: alarm, relay trip and reclose, lockout, keypad and settings.
`timescale 1ns/100ps
module aat_sequencer #(
  parameter int TENTH_CYCLES = aat_pkg::TENTH_CYCLES
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Arc intensity per channel, eight bits each, from on-chip logic
  input wire logic [63:0] arc_level,
  // Pins: keys (back, minus, plus, set) and manual restart, active high
  input wire logic [3:0] key_pin,
  input wire logic restart_pin,
  // Host word writes decoded by the serial slave
  input wire logic host_wr,
  input wire logic [15:0] host_wr_addr,
  input wire logic [15:0] host_wr_data,
  // Alarm and relay
  output logic display_alarm,
  output logic host_alarm,
  output logic [2:0] alarm_channel,
  output logic [2:0] alarm_count,
  output logic relay_close,
  output logic lockout,
  // Display
  output logic [7:0] screen,
  output logic [2:0] cursor,
  output logic [7:0] edit_value,
  output logic backlight_dim,
  output logic [15:0] bar_range,
  // Settings
  output logic [7:0] slave_addr,
  output logic [1:0] parity_select,
  output logic [2:0] baud_select,
  output logic alarm_mode,
  output logic [7:0] arc_threshold,
  output logic [7:0] instant_arc_time,
  output logic [7:0] repeat_arc_window
);

  // Two flip-flops on every pin before any logic sees it.
  logic [3:0] key_s1_reg;
  logic [3:0] key_s2_reg;
  logic [3:0] key_prev_reg;
  logic rst_s1_reg;
  logic rst_s2_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      key_s1_reg <= '0;
      key_s2_reg <= '0;
      key_prev_reg <= '0;
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else if (clk_en) begin
      key_s1_reg <= key_pin;
      key_s2_reg <= key_s1_reg;
      key_prev_reg <= key_s2_reg;
      rst_s1_reg <= restart_pin;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  logic [3:0] press;
  assign press = key_s2_reg & ~key_prev_reg;

  // Tenth-second time base shared by every timer.
  logic [aat_pkg::PRESC_W-1:0] presc_reg;
  logic [aat_pkg::PRESC_W-1:0] presc_next;
  logic tick;

  always_comb begin
    tick = (presc_reg == aat_pkg::PRESC_W'(TENTH_CYCLES - 1));
    presc_next = tick ? '0 : presc_reg + 1'b1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      presc_reg <= '0;
    end else if (clk_en) begin
      presc_reg <= presc_next;
    end
  end

  // Settings store, one byte per item, addressed by cursor index.
  logic [7:0] set_reg [aat_pkg::ITEMS];
  logic [7:0] set_next [aat_pkg::ITEMS];

  // Threshold compare over all channels; the lowest channel above it is reported.
  logic [7:0] over;
  logic [2:0] first_ch;

  always_comb begin
    first_ch = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      over[i] = arc_level[i*8 +: 8] > set_reg[aat_pkg::IT_THR];
      if (over[i]) begin
        first_ch = 3'(i);
      end
    end
  end

  aat_cls_if cif ();

  assign cif.tick = tick;
  assign cif.arc_on = |over;
  assign cif.iat_lim = aat_pkg::TW'(set_reg[aat_pkg::IT_IAT]) * aat_pkg::TENTHS_PER_S;
  assign cif.cat_lim = aat_pkg::TW'(set_reg[aat_pkg::IT_CAT]) * aat_pkg::TENTHS_PER_S;

  aat_arc_classifier u_cls (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .c(cif.cls)
  );

  // Single mode alarms on any onset; continuous mode only on a continuous event.
  logic raise;
  assign raise = (set_reg[aat_pkg::IT_MODE] == aat_pkg::MODE_SINGLE) ?
                 cif.onset : cif.cont_evt;

  logic host_clear;
  assign host_clear = host_wr && host_wr_addr == aat_pkg::HOST_CLEAR_ADDR &&
                      host_wr_data == aat_pkg::HOST_CLEAR_VALUE;
  logic local_clear;

  // Trip, reclose, lockout and pending alarm.
  aat_pkg::aat_trip_t trip_reg;
  aat_pkg::aat_trip_t trip_next;
  logic [aat_pkg::TW-1:0] reclose_reg;
  logic [aat_pkg::TW-1:0] reclose_next;
  logic [2:0] count_reg;
  logic [2:0] count_next;
  logic pend_reg;
  logic pend_next;
  logic [2:0] chan_reg;
  logic [2:0] chan_next;
  logic relay_reg;
  logic relay_next;

  always_comb begin
    trip_next = trip_reg;
    reclose_next = reclose_reg;
    count_next = count_reg;
    chan_next = chan_reg;
    pend_next = pend_reg;
    if (host_clear || local_clear) begin
      pend_next = 1'b0;
    end
    case (trip_reg)
      aat_pkg::TRIP_NORMAL: begin
        if (raise) begin
          count_next = count_reg + 1'b1;
          chan_next = first_ch;
          pend_next = 1'b1;
          reclose_next = '0;
          if (count_next >= aat_pkg::ALARM_MAX) begin
            trip_next = aat_pkg::TRIP_LOCKOUT;
          end else begin
            trip_next = aat_pkg::TRIP_OPEN;
          end
        end
      end
      aat_pkg::TRIP_OPEN: begin
        if (tick) begin
          reclose_next = reclose_reg + 1'b1;
          if (reclose_next >= aat_pkg::RECLOSE_TENTHS) begin
            trip_next = aat_pkg::TRIP_NORMAL;
          end
        end
      end
      aat_pkg::TRIP_LOCKOUT: begin
        reclose_next = '0;
      end
      default: begin
        trip_next = aat_pkg::TRIP_OPEN;
      end
    endcase
    // A manual restart wipes the count and lockout, like a power-up.
    if (rst_s2_reg) begin
      trip_next = aat_pkg::TRIP_NORMAL;
      count_next = aat_pkg::ALARM_ZERO;
      reclose_next = '0;
    end
    relay_next = (trip_next == aat_pkg::TRIP_NORMAL);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      trip_reg <= aat_pkg::TRIP_NORMAL;
      reclose_reg <= '0;
      count_reg <= aat_pkg::ALARM_ZERO;
      chan_reg <= 3'h0;
      pend_reg <= 1'b0;
      relay_reg <= 1'b1;
    end else if (clk_en) begin
      trip_reg <= trip_next;
      reclose_reg <= reclose_next;
      count_reg <= count_next;
      chan_reg <= chan_next;
      pend_reg <= pend_next;
      relay_reg <= relay_next;
    end
  end

  // Adjust a value by one step, held inside the item's legal range.
  function automatic logic [7:0] step_item(input logic [7:0] v, input logic up,
                                           input logic [2:0] it);
    logic [7:0] r;
    r = v;
    if (up && v < aat_pkg::ITEM_MAX[it]) begin
      r = v + 8'h01;
    end else if (!up && v > aat_pkg::ITEM_MIN[it]) begin
      r = v - 8'h01;
    end
    return r;
  endfunction

  // Keypad navigation, timeouts and parameter editing.
  aat_pkg::aat_screen_t scr_reg;
  aat_pkg::aat_screen_t scr_next;
  logic [2:0] cur_reg;
  logic [2:0] cur_next;
  logic [7:0] edit_reg;
  logic [7:0] edit_next;
  logic [aat_pkg::TW-1:0] idle_reg;
  logic [aat_pkg::TW-1:0] idle_next;
  logic [aat_pkg::TW-1:0] hold_reg;
  logic [aat_pkg::TW-1:0] hold_next;
  logic hold_done_reg;
  logic hold_done_next;
  logic dim_reg;
  logic dim_next;
  logic [15:0] bar_reg;
  logic [15:0] bar_next;

  always_comb begin
    scr_next = scr_reg;
    cur_next = cur_reg;
    edit_next = edit_reg;
    idle_next = idle_reg;
    hold_next = hold_reg;
    hold_done_next = hold_done_reg;
    dim_next = dim_reg;
    bar_next = bar_reg;
    local_clear = 1'b0;
    for (int i = 0; i < aat_pkg::ITEMS; i++) begin
      set_next[i] = set_reg[i];
    end
    if (host_wr && host_wr_addr == aat_pkg::HOST_BAR_ADDR) begin
      bar_next = host_wr_data;
    end
    // Idle timing restarts on any new press.
    if (|press) begin
      idle_next = '0;
      dim_next = 1'b0;
    end else if (tick && idle_reg < aat_pkg::DIM_TENTHS) begin
      idle_next = idle_reg + 1'b1;
      if (idle_next == aat_pkg::KEY_IDLE_TENTHS) begin
        scr_next = aat_pkg::SCR_DEFAULT;
      end
      if (idle_next == aat_pkg::DIM_TENTHS) begin
        dim_next = 1'b1;
      end
    end
    // Key handling; two-key chords take priority over single keys.
    if (|press) begin
      if (key_s2_reg[aat_pkg::K_MINUS] && key_s2_reg[aat_pkg::K_PLUS]) begin
        scr_next = aat_pkg::SCR_VERSION;
      end else if (key_s2_reg[aat_pkg::K_BACK] && key_s2_reg[aat_pkg::K_MINUS]) begin
        scr_next = aat_pkg::SCR_CALIB;
      end else if (key_s2_reg[aat_pkg::K_BACK] && key_s2_reg[aat_pkg::K_PLUS]) begin
        scr_next = aat_pkg::SCR_SELFCHECK;
      end else if (press[aat_pkg::K_BACK]) begin
        scr_next = aat_pkg::SCR_DEFAULT;
      end else if (press[aat_pkg::K_SET]) begin
        case (scr_reg)
          aat_pkg::SCR_BROWSE: begin
            edit_next = set_reg[cur_reg];
            scr_next = aat_pkg::SCR_EDIT;
          end
          aat_pkg::SCR_EDIT: begin
            set_next[cur_reg] = edit_reg;
            scr_next = aat_pkg::SCR_BROWSE;
          end
          default: begin
            cur_next = aat_pkg::IT_FIRST;
            scr_next = aat_pkg::SCR_BROWSE;
          end
        endcase
      end else if (press[aat_pkg::K_PLUS] || press[aat_pkg::K_MINUS]) begin
        if (scr_reg == aat_pkg::SCR_BROWSE) begin
          if (press[aat_pkg::K_PLUS]) begin
            cur_next = (cur_reg == aat_pkg::IT_LAST) ? aat_pkg::IT_FIRST : cur_reg + 1'b1;
          end else begin
            cur_next = (cur_reg == aat_pkg::IT_FIRST) ? aat_pkg::IT_LAST : cur_reg - 1'b1;
          end
        end else if (scr_reg == aat_pkg::SCR_EDIT) begin
          edit_next = step_item(edit_reg, press[aat_pkg::K_PLUS], cur_reg);
        end
      end
    end
    // Long back hold clears locally once per hold; the screen change wins over the press.
    if (!key_s2_reg[aat_pkg::K_BACK]) begin
      hold_next = '0;
      hold_done_next = 1'b0;
    end else if (tick && !hold_done_reg) begin
      hold_next = hold_reg + 1'b1;
      if (hold_next >= aat_pkg::CLEAR_HOLD_TENTHS) begin
        local_clear = 1'b1;
        hold_done_next = 1'b1;
        scr_next = aat_pkg::SCR_CLEARED;
      end
    end
    if (host_clear) begin
      scr_next = aat_pkg::SCR_CLEARED;
    end
    // A fresh alarm takes the display over.
    if (raise && trip_reg == aat_pkg::TRIP_NORMAL) begin
      scr_next = aat_pkg::SCR_ALARM;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scr_reg <= aat_pkg::SCR_DEFAULT;
      cur_reg <= aat_pkg::IT_FIRST;
      edit_reg <= 8'h00;
      idle_reg <= '0;
      hold_reg <= '0;
      hold_done_reg <= 1'b0;
      dim_reg <= 1'b0;
      bar_reg <= aat_pkg::BAR_RANGE_DEF;
      for (int i = 0; i < aat_pkg::ITEMS; i++) begin
        set_reg[i] <= aat_pkg::ITEM_DEF[i];
      end
    end else if (clk_en) begin
      scr_reg <= scr_next;
      cur_reg <= cur_next;
      edit_reg <= edit_next;
      idle_reg <= idle_next;
      hold_reg <= hold_next;
      hold_done_reg <= hold_done_next;
      dim_reg <= dim_next;
      bar_reg <= bar_next;
      for (int i = 0; i < aat_pkg::ITEMS; i++) begin
        set_reg[i] <= set_next[i];
      end
    end
  end

  // Outputs straight from flip-flops, except lockout, which is decoded from the trip state register.
  assign display_alarm = pend_reg;
  assign host_alarm = pend_reg;
  assign alarm_channel = chan_reg;
  assign alarm_count = count_reg;
  assign relay_close = relay_reg;
  assign lockout = (trip_reg == aat_pkg::TRIP_LOCKOUT);
  assign screen = scr_reg;
  assign cursor = cur_reg;
  assign edit_value = edit_reg;
  assign backlight_dim = dim_reg;
  assign bar_range = bar_reg;
  assign slave_addr = set_reg[aat_pkg::IT_ADDR];
  assign parity_select = set_reg[aat_pkg::IT_PAR][1:0];
  assign baud_select = set_reg[aat_pkg::IT_BAUD][2:0];
  assign alarm_mode = set_reg[aat_pkg::IT_MODE][0];
  assign arc_threshold = set_reg[aat_pkg::IT_THR];
  assign instant_arc_time = set_reg[aat_pkg::IT_IAT];
  assign repeat_arc_window = set_reg[aat_pkg::IT_CAT];

endmodule

//--- tb/aat_host_model.sv
// Model of the serial host and operator keypad facing the sequencer.
`timescale 1ns/100ps
module aat_host_model (
  // Clock
  input wire logic clk,
  // Pins and host word writes
  output logic [3:0] key_pin,
  output logic restart_pin,
  output logic host_wr,
  output logic [15:0] host_wr_addr,
  output logic [15:0] host_wr_data
);
  initial begin
    key_pin = 4'h0;
    restart_pin = 1'b0;
    host_wr = 1'b0;
    host_wr_addr = 16'h0000;
    host_wr_data = 16'h0000;
  end
  // Held six edges so the two-stage synchroniser surely sees the press.
  task automatic press(input logic [3:0] k);
    @(posedge clk);
    #1 key_pin = k;
    repeat (6) @(posedge clk);
    #1 key_pin = 4'h0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic restart();
    @(posedge clk);
    #1 restart_pin = 1'b1;
    repeat (6) @(posedge clk);
    #1 restart_pin = 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  // Released bus lines show the inverse so a stale value never passes.
  task automatic write(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    #1 host_wr = 1'b1;
    host_wr_addr = a;
    host_wr_data = d;
    @(posedge clk);
    #1 host_wr = 1'b0;
    host_wr_addr = ~a;
    host_wr_data = ~d;
    @(posedge clk);
    #1;
  endtask
endmodule

//--- tb/aat_sequencer_assertions.sv
// Concurrent checks on the ports of the arc alarm trip sequencer.
`timescale 1ns/100ps
module aat_sequencer_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Inputs watched
  input wire logic [63:0] arc_level,
  input wire logic host_wr,
  input wire logic [15:0] host_wr_addr,
  input wire logic [15:0] host_wr_data,
  // Outputs watched
  input wire logic display_alarm,
  input wire logic host_alarm,
  input wire logic [2:0] alarm_count,
  input wire logic relay_close,
  input wire logic lockout,
  input wire logic [7:0] screen,
  input wire logic [15:0] bar_range,
  input wire logic [7:0] slave_addr,
  input wire logic [1:0] parity_select,
  input wire logic [2:0] baud_select,
  input wire logic [7:0] instant_arc_time,
  input wire logic [7:0] repeat_arc_window,
  input wire logic backlight_dim
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_alarm_mirror: assert property (host_alarm == display_alarm)
    else $error("host alarm differs from display alarm");
  a_raise_opens: assert property ($rose(display_alarm) |-> !relay_close)
    else $error("alarm raised with relay closed");
  a_count_step: assert property ($rose(display_alarm) |->
    alarm_count == $past(alarm_count) + 3'h1)
    else $error("alarm count did not step");
  a_lock_count: assert property ($rose(lockout) |-> alarm_count == 3'h5)
    else $error("lockout at wrong count");
  a_lock_open: assert property (lockout |-> !relay_close)
    else $error("relay closed in lockout");
  a_host_clear: assert property (host_wr && host_wr_addr == 16'h0079 &&
    host_wr_data == 16'h0001 && arc_level == 64'h0000_0000_0000_0000
    |=> !display_alarm && screen == 8'h40)
    else $error("host clear not taken");
  a_bar_write: assert property (host_wr && host_wr_addr == 16'h0b16 |=>
    bar_range == $past(host_wr_data))
    else $error("bar range not written");
  a_addr_range: assert property (slave_addr inside {[8'h01:8'hf7]})
    else $error("slave address out of range");
  a_link_range: assert property (parity_select <= 2'h2 && baud_select <= 3'h4)
    else $error("link setting out of range");
  a_time_range: assert property (instant_arc_time inside {[8'h01:8'h05]} &&
    repeat_arc_window inside {[8'h05:8'h3c]})
    else $error("arc time setting out of range");
  c_lockout: cover property ($rose(lockout));
  c_version: cover property (screen == 8'h08);
  c_dim: cover property ($rose(backlight_dim));
endmodule
bind aat_sequencer aat_sequencer_checker chk (.*);

//--- tb/aat_sequencer_tb_top.sv
// Self-checking bench for the arc alarm trip sequencer.
`timescale 1ns/100ps
module aat_sequencer_tb_top;
  localparam int TC = 4;
  // Reclose takes 1800 ticks of TC clocks each.
  localparam int RECL = 1800 * TC;
  logic clk = 1'b0, reset = 1'b1, host_wr, restart_pin, display_alarm, host_alarm;
  logic relay_close, lockout, backlight_dim, alarm_mode, clk_en = 1'b1;
  logic [63:0] arc_level = 64'h0000_0000_0000_0000;
  logic [3:0] key_pin;
  logic [15:0] host_wr_addr, host_wr_data, bar_range;
  logic [2:0] alarm_channel, alarm_count, cursor, baud_select;
  logic [7:0] screen, edit_value, slave_addr, arc_threshold, instant_arc_time, repeat_arc_window;
  logic [1:0] parity_select;
  int fails = 0, checks = 0, cycles = 0;
  always #4 clk = ~clk;
  aat_host_model host (.clk(clk), .key_pin(key_pin), .restart_pin(restart_pin),
    .host_wr(host_wr), .host_wr_addr(host_wr_addr), .host_wr_data(host_wr_data));
  aat_sequencer #(.TENTH_CYCLES(TC)) uut (.clk(clk), .reset(reset), .clk_en(clk_en),
    .arc_level(arc_level), .key_pin(key_pin), .restart_pin(restart_pin), .host_wr(host_wr),
    .host_wr_addr(host_wr_addr), .host_wr_data(host_wr_data), .display_alarm(display_alarm),
    .host_alarm(host_alarm), .alarm_channel(alarm_channel), .alarm_count(alarm_count),
    .relay_close(relay_close), .lockout(lockout), .screen(screen), .cursor(cursor),
    .edit_value(edit_value), .backlight_dim(backlight_dim), .bar_range(bar_range),
    .slave_addr(slave_addr), .parity_select(parity_select), .baud_select(baud_select),
    .alarm_mode(alarm_mode), .arc_threshold(arc_threshold),
    .instant_arc_time(instant_arc_time), .repeat_arc_window(repeat_arc_window));
  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      print_verdict();
    end
  end
  // Arc of 0x90 on channel 3, above the 0x80 threshold, for four clocks.
  task automatic arc_pulse();
    @(posedge clk);
    #1 arc_level = 64'h0000_0000_9000_0000;
    repeat (4) @(posedge clk);
    #1 arc_level = 64'h0000_0000_0000_0000;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic t_defaults();
    check(slave_addr === 8'hf7 && parity_select === 2'h0, "address or parity");
    check(baud_select === 3'h2 && bar_range === 16'h000a, "baud or bar");
    check(relay_close === 1'b1 && alarm_count === 3'h0, "relay or count");
    check(arc_threshold === 8'h80 && alarm_mode === 1'b0, "threshold or mode");
    check(instant_arc_time === 8'h01 && repeat_arc_window === 8'h05, "arc times");
  endtask
  // Continuous mode: a lone short arc stays silent, a repeat inside the window alarms.
  task automatic t_cont();
    arc_pulse();
    repeat (220) @(posedge clk);
    check(display_alarm === 1'b0, "short arc alarmed");
    arc_pulse();
    arc_pulse();
    check(display_alarm === 1'b1 && relay_close === 1'b0, "repeat arc silent");
    host.restart();
    host.write(16'h0079, 16'h0001);
    check(alarm_count === 3'h0 && relay_close === 1'b1, "restart count");
    check(display_alarm === 1'b0, "clear after restart");
  endtask
  task automatic t_edit();
    host.press(4'h8);
    host.press(4'h8);
    host.press(4'h2);
    check(edit_value === 8'hf6, "address not stepped down");
    host.press(4'h1);
    check(screen === 8'h01 && slave_addr === 8'hf7, "edit not discarded");
    host.press(4'h8);
    repeat (3) host.press(4'h4);
    check(cursor === 3'h3, "cursor not on mode");
    host.press(4'h8);
    check(screen === 8'h04, "edit not entered");
    host.press(4'h4);
    host.press(4'h8);
    check(alarm_mode === 1'b1 && screen === 8'h02, "mode not committed");
  endtask
  task automatic t_chords();
    logic [3:0] k [3] = '{4'h6, 4'h3, 4'h5};
    logic [7:0] s [3] = '{8'h08, 8'h10, 8'h20};
    for (int i = 0; i < 3; i++) begin
      host.press(k[i]);
      check(screen === s[i], "chord screen wrong");
    end
  endtask
  task automatic t_alarm();
    arc_pulse();
    check(display_alarm === 1'b1 && host_alarm === 1'b1, "alarm not raised");
    check(relay_close === 1'b0 && alarm_channel === 3'h3, "relay or channel");
    check(alarm_count === 3'h1 && screen === 8'h80, "count or alarm screen");
    host.write(16'h0079, 16'h0001);
    check(display_alarm === 1'b0 && screen === 8'h40, "host clear");
    host.write(16'h0b16, 16'h0014);
    check(bar_range === 16'h0014, "bar range write");
    repeat (RECL - 200) @(posedge clk);
    #1 check(relay_close === 1'b0, "relay closed early");
    repeat (220) @(posedge clk);
    #1 check(relay_close === 1'b1, "relay not reclosed");
  endtask
  task automatic t_lockout();
    for (int i = 2; i <= 5; i++) begin
      arc_pulse();
      check(alarm_count === 3'(i), "count step");
      if (i < 5) repeat (RECL + 20) @(posedge clk);
    end
    check(lockout === 1'b1, "no lockout at five");
    repeat (RECL + 100) @(posedge clk);
    #1 check(relay_close === 1'b0 && lockout === 1'b1, "reclosed in lockout");
    arc_pulse();
    check(alarm_count === 3'h5, "raise counted in lockout");
    host.restart();
    check(alarm_count === 3'h0 && relay_close === 1'b1, "restart");
  endtask
  task automatic t_idle();
    host.press(4'h8);
    repeat (380) @(posedge clk);
    #1 check(screen === 8'h02, "left browse early");
    repeat (40) @(posedge clk);
    #1 check(screen === 8'h01 && backlight_dim === 1'b0, "idle return");
    repeat (200) @(posedge clk);
    #1 check(backlight_dim === 1'b1, "backlight not dimmed");
  endtask
  // With the enable low a press must leave every state alone.
  task automatic t_freeze();
    clk_en = 1'b0;
    host.press(4'h8);
    check(screen === 8'h01 && backlight_dim === 1'b1, "moved while frozen");
    clk_en = 1'b1;
    host.press(4'h8);
    check(screen === 8'h02 && backlight_dim === 1'b0, "press after thaw");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    t_defaults();
    t_cont();
    t_edit();
    t_chords();
    t_alarm();
    t_lockout();
    t_idle();
    t_freeze();
    print_verdict();
  end
endmodule
